// [hdl/mpucrs_pkg.sv]
package mpucrs_pkg;
  localparam int unsigned mpucrs_num_regions = 8;
  localparam int unsigned mpucrs_idx_w = 3;

  // register byte offsets on the apb window
  localparam logic [7:0] mpucrs_off_ctrl = 8'h04;
  localparam logic [7:0] mpucrs_off_rsel = 8'h08;
  localparam logic [7:0] mpucrs_off_base = 8'h0C;
  localparam logic [7:0] mpucrs_off_attr = 8'h10;

  // control fields
  localparam int unsigned mpucrs_ctrl_enable_bit = 0;
  localparam int unsigned mpucrs_ctrl_hfnmi_bit = 1;
  localparam int unsigned mpucrs_ctrl_bgmap_bit = 2;
  localparam logic [2:0] mpucrs_ctrl_reset = 3'h0;

  // region select and base fields
  localparam int unsigned mpucrs_rsel_w = 8;
  localparam logic [7:0] mpucrs_rsel_reset = 8'h00;
  localparam int unsigned mpucrs_base_valid_bit = 4;
  localparam int unsigned mpucrs_base_lsb = 5;
  localparam logic [26:0] mpucrs_base_reset = 27'h000_0000;

  // attribute/size fields
  localparam int unsigned mpucrs_attr_enable_bit = 0;
  localparam int unsigned mpucrs_attr_size_lsb = 1;
  localparam int unsigned mpucrs_attr_xn_bit = 28;
  localparam logic [4:0] mpucrs_size_min = 5'h04;
  localparam logic [4:0] mpucrs_size_full = 5'h1F;
  localparam logic [31:0] mpucrs_attr_reset = 32'h0000_0000;
  localparam logic [31:0] mpucrs_attr_mask = 32'h1000_003F;

  // system areas permitted while protection is on, except fetches from the system control space
  localparam logic [31:0] mpucrs_scs_base = 32'hE000_E000;
  localparam logic [31:0] mpucrs_scs_last = 32'hE000_EFFF;
  localparam logic [31:0] mpucrs_vtab_base = 32'h0000_0000;
  localparam logic [31:0] mpucrs_vtab_last = 32'h0000_03FF;

  typedef struct packed {
    logic [31:0] addr;
    logic priv;
    logic fetch;
    logic high_prio;
  } mpucrs_access_s;

  typedef struct packed {
    logic fault;
    logic allow;
    logic execute_never;
    logic strongly_ordered;
    logic background;
    logic [3:0] region;
  } mpucrs_result_s;

  typedef struct packed {
    logic [26:0] base;
    logic [4:0] size;
    logic enable;
    logic xn;
  } mpucrs_region_s;
endpackage : mpucrs_pkg

// [hdl/mpucrs_region_match.sv]
`timescale 1ns/1ps
module mpucrs_region_match
  import mpucrs_pkg::*;
(
  // region setting
  input mpucrs_pkg::mpucrs_region_s region,
  // address under test
  input wire logic [31:0] addr,
  // result
  output logic hit
);
  logic [31:0] mask;
  logic [31:0] base_addr;

  always_comb
  begin
    base_addr = {region.base, 5'h00};
    // size+1 bits of offset inside region; small sizes clamp to 32 bytes
    if (region.size == mpucrs_size_full)
      mask = 32'h0000_0000; // full map from address zero
    else if (region.size < mpucrs_size_min)
      mask = 32'hFFFF_FFE0;
    else
      mask = 32'hFFFF_FFFF << (region.size + 5'h01);
    hit = region.enable && ((addr & mask) == (base_addr & mask));
  end
endmodule : mpucrs_region_match

// [hdl/mpucrs_access_check.sv]
`timescale 1ns/1ps
module mpucrs_access_check
  import mpucrs_pkg::*;
(
  // control
  input wire logic prot_en,
  input wire logic hfnmi_en,
  input wire logic bgmap_en,
  // region hits and attributes
  input wire logic [7:0] hits,
  input wire logic [7:0] xn_bits,
  // access
  input mpucrs_pkg::mpucrs_access_s acc,
  // result
  output mpucrs_pkg::mpucrs_result_s res
);
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic active;
  logic scs;
  logic vtab;
  logic any_hit;
  logic [3:0] top;

  always_comb
  begin
    scs = in_range(acc.addr, mpucrs_scs_base, mpucrs_scs_last);
    vtab = in_range(acc.addr, mpucrs_vtab_base, mpucrs_vtab_last);
    // bypass in priority -1/-2 handlers unless enabled there
    active = prot_en && !(acc.high_prio && !hfnmi_en);
    any_hit = |hits;
    top = 4'h0;
    // last match wins so the highest number takes precedence
    for (int i = 0; i < 8; i++)
    begin
      if (hits[i])
        top = 4'(i);
    end
    res = '0;
    res.strongly_ordered = scs;
    if (!active)
    begin
      res.allow = !(scs && acc.fetch);
      res.background = 1'b1;
      res.region = 4'hF;
    end
    else if (scs || vtab)
    begin
      res.allow = !(scs && acc.fetch);
      res.region = 4'hF;
    end
    else if (any_hit)
    begin
      res.region = top;
      res.execute_never = xn_bits[top[2:0]];
      res.allow = !(acc.fetch && xn_bits[top[2:0]]);
    end
    else if (bgmap_en && acc.priv)
    begin
      res.allow = 1'b1; // background region -1
      res.background = 1'b1;
      res.region = 4'hF;
    end
    else
    begin
      res.allow = 1'b0;
      res.region = 4'hF;
    end
    if (scs)
      res.execute_never = 1'b1;
    // fault in the same cycle; allow is low so the core drops it
    res.fault = !res.allow;
  end
endmodule : mpucrs_access_check

// [hdl/mpucrs_top.sv]
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// How it works
// - control bit 0 enables protection; off means default map for all accesses.
// - on with background bit 0, accesses outside enabled regions and system areas fault.
// - on with background bit 1, privileged misses use default map as region -1.
// - on with background map, unprivileged misses fault.
// - background bit ignored while protection is off.
// - control bit 1 clear bypasses protection in priority -1/-2 handlers.
// - system control space is always execute-never and strongly ordered.
// - with protection on, vector table always allowed, system space allowed except for fetches.
// - protection off gives no privilege restriction.
// - region select bits 2:0 choose region 0 to 7.
// - base write with bit 4 clear updates selected region only.
// - base write with bit 4 set loads select from bits 3:0 first.
// - base valid bit reads zero.
// - base low region field reads current select.
// - base address lives in bits 31:N, lower bits reserved.
// - a 4GB region covers the full map from zero.
// - region size is two to the size field plus one, minimum 32 bytes.
// - overlapping regions resolve to highest number.
module mpucrs_top
  import mpucrs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core access check
  input wire logic acc_valid,
  input mpucrs_pkg::mpucrs_access_s acc,
  output logic acc_grant,
  output logic acc_fault,
  output mpucrs_pkg::mpucrs_result_s acc_res
);
  import mpucrs_pkg::*;

  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  logic [7:0] rsel_reg;
  logic [7:0] rsel_next;
  logic [26:0] base_reg [mpucrs_num_regions];
  logic [26:0] base_next [mpucrs_num_regions];
  logic [31:0] attr_reg [mpucrs_num_regions];
  logic [31:0] attr_next [mpucrs_num_regions];
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic ack_reg;
  logic ack_next;
  logic acc_phase;

  logic wr_en;
  logic rd_en;
  logic [2:0] wr_idx;
  logic [7:0] hits;
  logic [7:0] xn_bits;
  mpucrs_result_s res;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == mpucrs_off_ctrl) || (a == mpucrs_off_rsel) ||
      (a == mpucrs_off_base) || (a == mpucrs_off_attr);
  endfunction : addr_known

  // one wait state: read data and error come from flops yet stand with pready
  assign acc_phase = psel && penable && clk_en;
  assign pready = ack_reg;
  assign wr_en = acc_phase && pwrite && ack_reg;
  assign rd_en = acc_phase && !pwrite && !ack_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    rsel_next = rsel_reg;
    base_next = base_reg;
    attr_next = attr_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    ack_next = acc_phase && !ack_reg;
    wr_idx = rsel_reg[2:0];
    if (psel && penable && !ack_reg && !addr_known(paddr))
      pslverr_next = 1'b1;
    if (wr_en)
    begin
      unique case (paddr)
        mpucrs_off_ctrl:
          ctrl_next = pwdata[2:0];
        mpucrs_off_rsel:
          rsel_next = pwdata[7:0];
        mpucrs_off_base:
        begin
          if (pwdata[mpucrs_base_valid_bit])
          begin
            // select and base update in one write
            rsel_next = {4'h0, pwdata[3:0]};
            wr_idx = pwdata[2:0];
          end
          // bit 4 clear keeps select and ignores region field
          base_next[wr_idx] = pwdata[31:mpucrs_base_lsb];
        end
        mpucrs_off_attr:
          attr_next[wr_idx] = pwdata & mpucrs_attr_mask;
        default:
        begin
        end
      endcase
    end
    if (rd_en)
    begin
      unique case (paddr)
        mpucrs_off_ctrl:
          prdata_next = {29'h0, ctrl_reg};
        mpucrs_off_rsel:
          prdata_next = {24'h0, rsel_reg};
        mpucrs_off_base:
          // valid bit reads zero, region field mirrors select
          prdata_next = {base_reg[rsel_reg[2:0]], 1'b0, rsel_reg[3:0]};
        mpucrs_off_attr:
          prdata_next = attr_reg[rsel_reg[2:0]];
        default:
          prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= mpucrs_ctrl_reset;
      rsel_reg <= mpucrs_rsel_reset;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      ack_reg <= 1'b0;
      for (int i = 0; i < mpucrs_num_regions; i++)
      begin
        base_reg[i] <= mpucrs_base_reset;
        attr_reg[i] <= mpucrs_attr_reset;
      end
    end
    else if (clk_en)
    begin
      ctrl_reg <= ctrl_next;
      rsel_reg <= rsel_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      ack_reg <= ack_next;
      base_reg <= base_next;
      attr_reg <= attr_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < mpucrs_num_regions; g++)
    begin : g_region
      mpucrs_region_s rs;
      assign rs.base = base_reg[g];
      assign rs.size = attr_reg[g][5:1];
      assign rs.enable = attr_reg[g][mpucrs_attr_enable_bit];
      assign rs.xn = attr_reg[g][mpucrs_attr_xn_bit];
      assign xn_bits[g] = rs.xn;
      mpucrs_region_match u_match (
        .region(rs),
        .addr(acc.addr),
        .hit(hits[g])
      );
    end
  endgenerate

  // handler enable with protection off is left as found; software keeps it clear
  mpucrs_access_check u_check (
    .prot_en(ctrl_reg[mpucrs_ctrl_enable_bit]),
    .hfnmi_en(ctrl_reg[mpucrs_ctrl_hfnmi_bit]),
    .bgmap_en(ctrl_reg[mpucrs_ctrl_bgmap_bit]),
    .hits(hits),
    .xn_bits(xn_bits),
    .acc(acc),
    .res(res)
  );

  // checked combinationally so the core sees the verdict in the same cycle
  assign acc_grant = acc_valid && res.allow;
  assign acc_fault = acc_valid && res.fault;
  assign acc_res = res;
endmodule : mpucrs_top

// [sim/mpucrs_top_asserts.sv]
`timescale 1ns/1ps
module mpucrs_checker
  import mpucrs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // access
  input wire logic acc_valid,
  input mpucrs_pkg::mpucrs_access_s acc,
  input wire logic acc_grant,
  input wire logic acc_fault,
  input mpucrs_pkg::mpucrs_result_s acc_res
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] ctl_reg, ctl_next;
  logic acs, scs, sys, on, miss;
  // a transfer completes only at the edge where pready stands high
  assign acs = psel && penable && pready && clk_en;
  assign scs = acc.addr inside {[mpucrs_scs_base:mpucrs_scs_last]};
  assign sys = scs || acc.addr <= mpucrs_vtab_last;
  // handler bypass counts as protection off
  assign on = ctl_reg[0] && !(acc.high_prio && !ctl_reg[1]);
  assign miss = acc_valid && on && !sys && acc_res.region == 4'hF;
  always_comb
  begin
    ctl_next = ctl_reg;
    if (acs && pwrite && paddr == mpucrs_off_ctrl)
      ctl_next = pwdata[2:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_reg <= 3'h0;
    else
      ctl_reg <= ctl_next;
  end
  one_way_a: assert property (!(acc_grant && acc_fault)) else $error("grant with fault");
  same_cycle_a: assert property (acc_fault == (acc_valid && acc_res.fault)) else $error("fault late");
  scs_attr_a: assert property (acc_valid && scs |-> acc_res.execute_never && acc_res.strongly_ordered)
    else $error("scs attributes");
  off_grant_a: assert property (acc_valid && !on && !(scs && acc.fetch) |-> acc_grant)
    else $error("bypass refused");
  miss_a: assert property (miss && (!ctl_reg[2] || !acc.priv) |-> acc_fault) else $error("miss let by");
  bg_a: assert property (miss && ctl_reg[2] && acc.priv |-> acc_grant && acc_res.background)
    else $error("background refused");
  sys_a: assert property (acc_valid && on && sys && !acc.fetch |-> acc_grant) else $error("system refused");
  valid_rd_a: assert property (acs && !pwrite && paddr == mpucrs_off_base |-> !prdata[4])
    else $error("valid bit read high");
  cover property (miss && ctl_reg[2] && acc.priv);
  cover property (acc_valid && acc.high_prio && !on);
  cover property (acc_valid && acc_res.region == 4'h7);
endmodule : mpucrs_checker

bind mpucrs_top mpucrs_checker i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .acc_valid(acc_valid), .acc(acc), .acc_grant(acc_grant), .acc_fault(acc_fault), .acc_res(acc_res));

// [sim/mpucrs_core_model.sv]
`timescale 1ns/1ps
module mpucrs_core_model
  import mpucrs_pkg::*;
(
  // clock
  input wire logic pclk,
  // access path
  output logic acc_valid,
  output mpucrs_pkg::mpucrs_access_s acc
);
  initial
  begin
    acc_valid = 1'b0;
    acc = '0;
  end
  // k is priv, fetch, high priority handler
  task automatic issue(input logic [31:0] a, input logic [2:0] k);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc <= {a, k};
    #1;
  endtask : issue
  // valid dropped and address inverted so a stale value is never granted
  task automatic release_bus;
    @(posedge pclk);
    acc_valid <= 1'b0;
    acc.addr <= ~acc.addr;
  endtask : release_bus
endmodule : mpucrs_core_model

// [sim/mpucrs_top_bench.sv]
`timescale 1ns/1ps
module mpucrs_top_bench;
  import mpucrs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [32:0] rd_val = 33'h0_0000_0000;
  logic pready, pslverr, acc_valid, acc_grant, acc_fault;
  mpucrs_access_s acc;
  mpucrs_result_s acc_res;
  int errors = 0;
  int tests_run = 0;
  always #12.5 pclk = ~pclk;
  mpucrs_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc(acc), .acc_grant(acc_grant), .acc_fault(acc_fault), .acc_res(acc_res));
  mpucrs_core_model i_core (.pclk(pclk), .acc_valid(acc_valid), .acc(acc));
  task automatic print_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    // response taken at the completing edge, before it is released
    rd_val = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic s);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_val, {s, e});
  endtask : rd
  task automatic ac(input logic [31:0] a, input logic [2:0] k, input logic [5:0] e);
    i_core.issue(a, k);
    chk({27'h0, acc_grant, acc_fault, acc_res.region}, {27'h0, e});
  endtask : ac
  task automatic t_off;
    rd(mpucrs_off_ctrl, 32'h0000_0000, 1'b0);
    rd(8'h00, 32'h0000_0000, 1'b1);
    ac(32'h3000_0000, 3'b000, 6'h2F);
    apb(1'b1, mpucrs_off_ctrl, 32'h0000_0004);
    ac(32'h3000_0000, 3'b000, 6'h2F);
    ac(32'hE000_E100, 3'b010, 6'h1F);
  endtask : t_off
  task automatic t_sel;
    apb(1'b1, mpucrs_off_rsel, 32'h0000_0005);
    apb(1'b1, mpucrs_off_base, 32'h2000_0002);
    rd(mpucrs_off_rsel, 32'h0000_0005, 1'b0);
    rd(mpucrs_off_base, 32'h2000_0005, 1'b0);
    apb(1'b1, mpucrs_off_base, 32'h2000_0013);
    rd(mpucrs_off_rsel, 32'h0000_0003, 1'b0);
    rd(mpucrs_off_base, 32'h2000_0003, 1'b0);
    apb(1'b1, mpucrs_off_attr, 32'h0000_0013);
  endtask : t_sel
  // clock enable low in mid access stretches it; the write lands once
  task automatic t_hold;
    fork
      apb(1'b1, mpucrs_off_rsel, 32'h0000_0006);
      begin
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    rd(mpucrs_off_rsel, 32'h0000_0006, 1'b0);
  endtask : t_hold
  task automatic t_prot;
    apb(1'b1, mpucrs_off_ctrl, 32'h0000_0001);
    ac(32'h2000_03FC, 3'b000, 6'h23);
    ac(32'h2000_0400, 3'b000, 6'h1F);
    ac(32'h3000_0000, 3'b100, 6'h1F);
    ac(32'h0000_0100, 3'b000, 6'h2F);
    ac(32'h3000_0000, 3'b001, 6'h2F);
    apb(1'b1, mpucrs_off_ctrl, 32'h0000_0003);
    ac(32'h3000_0000, 3'b001, 6'h1F);
    apb(1'b1, mpucrs_off_ctrl, 32'h0000_0005);
    ac(32'h3000_0000, 3'b100, 6'h2F);
    ac(32'h2000_0000, 3'b100, 6'h23);
    ac(32'h3000_0000, 3'b000, 6'h1F);
  endtask : t_prot
  task automatic t_over;
    apb(1'b1, mpucrs_off_base, 32'h0000_0017);
    apb(1'b1, mpucrs_off_attr, 32'h0000_003F);
    ac(32'h2000_0010, 3'b000, 6'h27);
    ac(32'hF000_0000, 3'b000, 6'h27);
    apb(1'b1, mpucrs_off_attr, 32'h1000_003F);
    ac(32'hF000_0000, 3'b010, 6'h17);
    i_core.release_bus;
  endtask : t_over
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_off;
    t_sel;
    t_hold;
    t_prot;
    t_over;
    print_verdict;
  end
  // whole run needs about 115 cycles
  initial
  begin
    repeat (3000) @(posedge pclk);
    errors++;
    print_verdict;
  end
endmodule : mpucrs_top_bench
